// *** logic/ir_remote_pkg.sv ***
// constants, types and register map of the infrared remote command handler
// assumes a 40 MHz system clock and a decoder that reports button presses
package ir_remote_pkg;

  // ----------------------------------------------------------------
  // register map (word index on the plain register port)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] A_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] A_CFG_SENS = 4'h1;
  localparam logic [ADDR_W-1:0] A_CFG_DELAY = 4'h2;
  localparam logic [ADDR_W-1:0] A_CFG_TWI = 4'h3;
  localparam logic [ADDR_W-1:0] A_EVENT = 4'h4;
  localparam logic [ADDR_W-1:0] A_FACTOR = 4'h5;
  localparam logic [ADDR_W-1:0] A_TWI_BUS = 4'h6;
  localparam logic [ADDR_W-1:0] A_STATUS = 4'h7;
  localparam logic [ADDR_W-1:0] A_SENS = 4'h8;
  localparam logic [ADDR_W-1:0] A_DELAY = 4'h9;
  localparam logic [ADDR_W-1:0] A_TWI = 4'ha;
  localparam logic [ADDR_W-1:0] A_LEARN = 4'hb;

  // event register bits (write one to fire)
  localparam int EV_DOWNLOAD = 0;
  localparam int EV_TEACH = 1;
  localparam int EV_BUS_RETURN = 2;

  // ----------------------------------------------------------------
  // sensitivity levels per sector
  // ----------------------------------------------------------------
  localparam int SECTORS = 3;
  localparam int SENS_W = 3;
  localparam int SENS_ALL_W = SECTORS * SENS_W;
  localparam logic [SENS_W-1:0] SENS_OFF = 3'h0;
  localparam logic [SENS_W-1:0] SENS_MIN = 3'h1; // 25 %
  localparam logic [SENS_W-1:0] SENS_MAX = 3'h4; // 100 %

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 25;
  localparam int ONE_SEC_NS = 1_000_000_000;
  localparam int SEC_CYC_DEF = ONE_SEC_NS / CLK_NS;
  localparam int FLASH_MS = 200;
  localparam int FLASH_CYC_DEF = FLASH_MS * 1_000_000 / CLK_NS;
  localparam int HOLD_UNIT_MS = 100;
  localparam int RESET_HOLD_MS = 3000;
  localparam logic [7:0] RESET_HOLD_UNITS = 8'(RESET_HOLD_MS / HOLD_UNIT_MS);
  localparam int LEARN_MAX_H = 255;
  localparam int SEC_PER_H = 3600;
  localparam int DLY_W = 20;
  localparam logic [DLY_W-1:0] LEARN_MAX_S = DLY_W'(LEARN_MAX_H * SEC_PER_H);

  // delay presets in seconds, twilight presets in lux
  localparam logic [DLY_W-1:0] DLY_10S = 20'h0000a;
  localparam logic [DLY_W-1:0] DLY_30S = 20'h0001e;
  localparam logic [DLY_W-1:0] DLY_2M = 20'h00078;
  localparam logic [DLY_W-1:0] DLY_5M = 20'h0012c;
  localparam logic [DLY_W-1:0] DLY_30M = 20'h00708;
  localparam logic [15:0] LUX_10 = 16'h000a;
  localparam logic [15:0] LUX_50 = 16'h0032;
  localparam logic [15:0] LUX_150 = 16'h0096;

  // reset values of the stored configuration
  localparam logic [SENS_ALL_W-1:0] RST_SENS = 9'h0db;
  localparam logic [DLY_W-1:0] RST_DELAY = 20'h0000a;
  localparam logic [15:0] RST_TWI = 16'h0064;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_AUTO = 3'b001,
    MODE_ON = 3'b010,
    MODE_OFF = 3'b100
  } mode_t;

  typedef enum logic [4:0] {
    CMD_ON = 5'h00, CMD_AUTO = 5'h01, CMD_OFF = 5'h02,
    CMD_SENS_DN = 5'h03, CMD_SENS_EQ = 5'h04, CMD_SENS_UP = 5'h05,
    CMD_TWI_10 = 5'h06, CMD_TWI_50 = 5'h07, CMD_TWI_150 = 5'h08, CMD_TWI_DAY = 5'h09,
    CMD_TEACH = 5'h0a,
    CMD_DLY_10S = 5'h0b, CMD_DLY_30S = 5'h0c, CMD_DLY_2M = 5'h0d, CMD_DLY_5M = 5'h0e,
    CMD_DLY_30M = 5'h0f, CMD_START = 5'h10, CMD_STOP = 5'h11, CMD_TEST = 5'h12,
    CMD_RESET = 5'h13
  } cmd_t;

  typedef enum logic [1:0] {
    ADJ_NONE = 2'h0, ADJ_DOWN = 2'h1, ADJ_UP = 2'h2
  } adj_t;

  typedef struct packed {
    logic valid;
    cmd_t code;
    logic [7:0] hold; // press duration so far, in hold units
  } cmd_in_t;

  typedef struct packed {
    logic fb1_inact;
    logic fb1_dis;
    logic ir_dis;
    logic dim_min;
    logic test_en;
    logic restore;
    logic twi_dep;
    logic app_light;
  } ctrl_t;

  typedef struct packed {
    logic force_max;
    logic dim_min;
    logic stepdown;
    logic startup;
    logic end_det;
    logic begin_det;
  } tx_t;

endpackage

// *** logic/ir_remote_command_handler.sv ***
// infrared remote command handler for motion function block 1
// assumes decoder, adjuster and measured brightness run on i_clk
//
// Behaviour
// - off locks block 1 manually
// - ceiling off sends end, maybe brightness-dependent
// - light-control off steps down or dims min
// - block off discards on/off, back auto
// - bus return restores mode only if set
// - ir disable keeps manual preset
// - manual keeps settings, ignores start/stop
// - walk entry keeps mode, exit auto
// - sensitivity shifts one level, equalise restores
// - sensitivity clamped 25-100 %, never toggles off
// - last sensitivity source wins
// - twilight buttons load 10/50/150 lux, day
// - remote teach stores measured brightness
// - twilight buttons need brightness-dependent config
// - twilight value retained until new setting
// - delay presets, retained, limited overwriters
// - start launches timer, begin or startup
// - stop adopts time, ends, re-enables block
// - timer saturates 255 h, then discarded
// - listed events abort learning, keep delay, a delay preset loads its value
// - factor ignored while learning, twilight works
// - walk test accepts only sensitivity, test
// - reset after 3 s hold restores config
// - accepted command flashes indicator
// - only block 1 is touched
// - auto cancels lock without telegram
`timescale 1ns/1ps

module ir_remote_command_handler
#(
  parameter int SEC_CYC = ir_remote_pkg::SEC_CYC_DEF,
  parameter int FLASH_CYC = ir_remote_pkg::FLASH_CYC_DEF
)
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire ir_remote_pkg::cmd_in_t i_cmd,
  input wire logic i_adj_valid,
  input wire ir_remote_pkg::adj_t i_adj_step,
  input wire logic [15:0] i_brightness,
  input wire logic i_presence,
  input wire logic [ir_remote_pkg::ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output ir_remote_pkg::mode_t o_mode,
  output logic o_fb1_hold,
  output logic o_walk_test,
  output logic o_bright_indep,
  output ir_remote_pkg::tx_t o_tx,
  output logic [ir_remote_pkg::SENS_ALL_W-1:0] o_sens,
  output logic [ir_remote_pkg::DLY_W-1:0] o_delay_s,
  output logic [15:0] o_twilight,
  output logic o_twi_day,
  output logic o_ack_led
);
  import ir_remote_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    ctrl_t ctrl;
    logic [SENS_ALL_W-1:0] sens_cfg;
    logic [DLY_W-1:0] delay_cfg;
    logic [15:0] twi_cfg;
    mode_t mode;
    logic walk;
    logic fb1_hold;
    logic learn;
    logic [DLY_W-1:0] learn_s;
    logic [31:0] pre;
    logic bright_indep;
    logic [SENS_ALL_W-1:0] sens;
    logic [DLY_W-1:0] delay;
    logic [15:0] twi;
    logic twi_day;
    logic rst_fired;
    logic [31:0] flash;
    logic ack_led;
    tx_t tx;
    logic [31:0] rdata;
  } state_t;

  state_t q;
  state_t d;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic [SENS_ALL_W-1:0] sens_dn;
  logic [SENS_ALL_W-1:0] sens_up;
  logic cmd_new;
  logic go;
  logic fb1_off;
  logic manual;
  logic walk_ok;
  logic is_twi;
  logic is_dly;
  logic on_go;
  logic off_go;
  logic auto_go;
  logic sens_go;
  logic twi_go;
  logic dly_go;
  logic start_go;
  logic stop_go;
  logic test_go;
  logic rst_go;
  logic timeout;
  logic abort;
  logic ev_dl;
  logic ev_teach;
  logic ev_ret;
  logic wr_factor;

  // clamp keeps a disabled sector off and an enabled one at 25 % or more
  for (genvar g = 0; g < SECTORS; g++)
  begin : g_sec
    logic [SENS_W-1:0] c;
    assign c = q.sens_cfg[g*SENS_W +: SENS_W];
    assign sens_dn[g*SENS_W +: SENS_W] = (c > SENS_MIN) ? c - 3'h1 : c;
    assign sens_up[g*SENS_W +: SENS_W] = (c != SENS_OFF && c < SENS_MAX) ? c + 3'h1 : c;
  end

  // repeats of a held button are dropped, only reset looks at the hold time
  assign cmd_new = i_cmd.valid && !q.ctrl.ir_dis;
  assign fb1_off = q.ctrl.fb1_dis || q.ctrl.fb1_inact;
  assign manual = q.mode != MODE_AUTO;
  assign walk_ok = i_cmd.code inside {CMD_SENS_DN, CMD_SENS_EQ, CMD_SENS_UP, CMD_TEST};
  assign is_twi = i_cmd.code inside {CMD_TWI_10, CMD_TWI_50, CMD_TWI_150, CMD_TWI_DAY,
    CMD_TEACH};
  assign is_dly = i_cmd.code inside {CMD_DLY_10S, CMD_DLY_30S, CMD_DLY_2M, CMD_DLY_5M,
    CMD_DLY_30M};
  assign go = cmd_new && i_cmd.hold == 8'h00 && (!q.walk || walk_ok);
  assign on_go = go && i_cmd.code == CMD_ON && !fb1_off;
  assign off_go = go && i_cmd.code == CMD_OFF && !fb1_off;
  assign auto_go = go && i_cmd.code == CMD_AUTO;
  assign sens_go = go && i_cmd.code inside {CMD_SENS_DN, CMD_SENS_EQ, CMD_SENS_UP};
  assign twi_go = go && is_twi && q.ctrl.twi_dep;
  assign dly_go = go && is_dly;
  assign start_go = go && i_cmd.code == CMD_START && !manual && !q.learn && !fb1_off;
  assign stop_go = go && i_cmd.code == CMD_STOP && !manual && q.learn;
  assign test_go = go && i_cmd.code == CMD_TEST && q.ctrl.test_en;
  assign rst_go = cmd_new && !q.walk && i_cmd.code == CMD_RESET && !q.rst_fired
    && i_cmd.hold >= RESET_HOLD_UNITS;
  assign timeout = q.learn && q.learn_s == LEARN_MAX_S;
  assign abort = q.learn && (dly_go || fb1_off || (test_go && !q.walk) || q.ctrl.ir_dis
    || on_go || off_go || timeout);
  assign ev_dl = i_wr && i_addr == A_EVENT && i_wdata[EV_DOWNLOAD];
  assign ev_teach = i_wr && i_addr == A_EVENT && i_wdata[EV_TEACH];
  assign ev_ret = i_wr && i_addr == A_EVENT && i_wdata[EV_BUS_RETURN];
  assign wr_factor = i_wr && i_addr == A_FACTOR;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;
    d.tx = '0;
    d.rdata = '0;

    // register writes
    if (i_wr && i_addr == A_CTRL)
    begin
      d.ctrl = i_wdata[$bits(ctrl_t)-1:0];
    end
    else if (i_wr && i_addr == A_CFG_SENS)
    begin
      d.sens_cfg = i_wdata[SENS_ALL_W-1:0];
    end
    else if (i_wr && i_addr == A_CFG_DELAY)
    begin
      d.delay_cfg = i_wdata[DLY_W-1:0];
    end
    else if (i_wr && i_addr == A_CFG_TWI)
    begin
      d.twi_cfg = i_wdata[15:0];
    end
    else if (i_wr && i_addr == A_TWI_BUS)
    begin
      d.twi = i_wdata[15:0];
      d.twi_day = 1'b0;
    end

    // register reads, data stand in the next cycle only
    if (i_rd && i_addr == A_CTRL)
    begin
      d.rdata = 32'(q.ctrl);
    end
    else if (i_rd && i_addr == A_CFG_SENS)
    begin
      d.rdata = 32'(q.sens_cfg);
    end
    else if (i_rd && i_addr == A_CFG_DELAY)
    begin
      d.rdata = 32'(q.delay_cfg);
    end
    else if (i_rd && i_addr == A_CFG_TWI)
    begin
      d.rdata = 32'(q.twi_cfg);
    end
    else if (i_rd && i_addr == A_STATUS)
    begin
      d.rdata = 32'({q.twi_day, q.bright_indep, q.fb1_hold, q.learn, q.walk, q.mode});
    end
    else if (i_rd && i_addr == A_SENS)
    begin
      d.rdata = 32'(q.sens);
    end
    else if (i_rd && i_addr == A_DELAY)
    begin
      d.rdata = 32'(q.delay);
    end
    else if (i_rd && i_addr == A_TWI)
    begin
      d.rdata = 32'(q.twi);
    end
    else if (i_rd && i_addr == A_LEARN)
    begin
      d.rdata = 32'(q.learn_s);
    end

    // configuration download, adjuster, bus objects
    if (ev_dl)
    begin
      d.sens = q.sens_cfg;
      d.delay = q.delay_cfg;
      d.twi = q.twi_cfg;
      d.twi_day = 1'b0;
    end
    if (i_adj_valid)
    begin
      case (i_adj_step)
        ADJ_DOWN: d.sens = sens_dn;
        ADJ_UP: d.sens = sens_up;
        default: d.sens = q.sens_cfg;
      endcase
    end
    if (wr_factor && !q.learn)
    begin
      d.delay = i_wdata[DLY_W-1:0];
    end
    if (ev_teach)
    begin
      d.twi = i_brightness;
      d.twi_day = 1'b0;
    end

    // learning timer, counts whole seconds
    if (q.learn)
    begin
      if (q.pre == 32'(SEC_CYC - 1))
      begin
        d.pre = '0;
        d.learn_s = (q.learn_s == LEARN_MAX_S) ? q.learn_s : q.learn_s + 20'h00001;
      end
      else
      begin
        d.pre = q.pre + 32'h1;
      end
    end

    // operating mode buttons; telegrams go to block 1 outputs only
    if (on_go)
    begin
      d.mode = MODE_ON;
      if (q.ctrl.app_light)
      begin
        d.tx.force_max = i_presence;
        d.tx.startup = !i_presence;
      end
      else
      begin
        d.tx.begin_det = 1'b1;
        d.bright_indep = 1'b1;
      end
    end
    if (off_go)
    begin
      d.mode = MODE_OFF;
      if (q.ctrl.app_light)
      begin
        d.tx.stepdown = i_presence && !q.ctrl.dim_min;
        d.tx.dim_min = i_presence && q.ctrl.dim_min;
      end
      else
      begin
        d.tx.end_det = 1'b1;
        d.bright_indep = !q.ctrl.twi_dep;
      end
    end
    if (auto_go)
    begin
      d.mode = MODE_AUTO;
      d.bright_indep = 1'b0;
    end

    // sensitivity buttons
    if (sens_go)
    begin
      case (i_cmd.code)
        CMD_SENS_DN: d.sens = sens_dn;
        CMD_SENS_UP: d.sens = sens_up;
        default: d.sens = q.sens_cfg;
      endcase
    end

    // twilight buttons
    if (twi_go)
    begin
      d.twi_day = 1'b0;
      case (i_cmd.code)
        CMD_TWI_10: d.twi = LUX_10;
        CMD_TWI_50: d.twi = LUX_50;
        CMD_TWI_150: d.twi = LUX_150;
        CMD_TWI_DAY: d.twi_day = 1'b1;
        default: d.twi = i_brightness;
      endcase
    end

    // delay presets
    if (dly_go)
    begin
      case (i_cmd.code)
        CMD_DLY_10S: d.delay = DLY_10S;
        CMD_DLY_30S: d.delay = DLY_30S;
        CMD_DLY_2M: d.delay = DLY_2M;
        CMD_DLY_5M: d.delay = DLY_5M;
        default: d.delay = DLY_30M;
      endcase
    end

    // learning start and stop
    if (start_go)
    begin
      d.learn = 1'b1;
      d.learn_s = '0;
      d.pre = '0;
      d.fb1_hold = 1'b1;
      d.tx.begin_det = !q.ctrl.app_light;
      d.tx.startup = q.ctrl.app_light;
    end
    if (stop_go && !timeout)
    begin
      d.learn = 1'b0;
      d.fb1_hold = 1'b0;
      d.delay = q.learn_s;
      d.tx.end_det = !q.ctrl.app_light;
      d.tx.stepdown = q.ctrl.app_light;
    end
    if (abort)
    begin
      d.learn = 1'b0;
      d.fb1_hold = 1'b0;
      d.delay = (dly_go || !wr_factor) ? d.delay : q.delay;
    end

    // walking test
    if (test_go)
    begin
      d.walk = !q.walk;
      if (q.walk)
      begin
        d.mode = MODE_AUTO;
        d.bright_indep = 1'b0;
      end
    end

    // long-press reset, once per press
    if (cmd_new && i_cmd.code == CMD_RESET && i_cmd.hold < RESET_HOLD_UNITS)
    begin
      d.rst_fired = 1'b0;
    end
    if (rst_go)
    begin
      d.rst_fired = 1'b1;
      d.sens = q.sens_cfg;
      d.delay = q.delay_cfg;
      d.twi = q.twi_cfg;
      d.twi_day = 1'b0;
    end

    // block 1 off drops the preset; bus return picks the mode
    if (fb1_off)
    begin
      d.mode = MODE_AUTO;
      d.bright_indep = 1'b0;
    end
    else if (ev_ret && !q.ctrl.restore)
    begin
      d.mode = MODE_AUTO;
      d.bright_indep = 1'b0;
    end

    // acknowledge flash
    if (on_go || off_go || auto_go || sens_go || twi_go || dly_go || start_go || stop_go
      || test_go || rst_go)
    begin
      d.flash = 32'(FLASH_CYC - 1);
      d.ack_led = 1'b1;
    end
    else if (q.flash != 32'h0)
    begin
      d.flash = q.flash - 32'h1;
    end
    else
    begin
      d.ack_led = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      q <= '0;
      q.ctrl.test_en <= 1'b1;
      q.mode <= MODE_AUTO;
      q.sens_cfg <= RST_SENS;
      q.sens <= RST_SENS;
      q.delay_cfg <= RST_DELAY;
      q.delay <= RST_DELAY;
      q.twi_cfg <= RST_TWI;
      q.twi <= RST_TWI;
    end
    else
    begin
      q <= d;
    end
  end

  assign o_rdata = q.rdata;
  assign o_mode = q.mode;
  assign o_fb1_hold = q.fb1_hold;
  assign o_walk_test = q.walk;
  assign o_bright_indep = q.bright_indep;
  assign o_tx = q.tx;
  assign o_sens = q.sens;
  assign o_delay_s = q.delay;
  assign o_twilight = q.twi;
  assign o_twi_day = q.twi_day;
  assign o_ack_led = q.ack_led;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_learn_start;
    start_go ##1 (q.learn && q.fb1_hold);
  endsequence

  a_off_locks: assert property (off_go && !fb1_off |=> q.mode == MODE_OFF)
    else $error("off command did not lock block 1");
  a_off_end_tx: assert property (off_go && !q.ctrl.app_light |=> o_tx.end_det)
    else $error("off command sent no end telegram");
  a_off_stepdown: assert property (off_go && q.ctrl.app_light && i_presence
    |=> (o_tx.stepdown || o_tx.dim_min) && !o_tx.end_det)
    else $error("off command did not step down");
  a_fb1_auto: assert property (fb1_off |=> q.mode == MODE_AUTO)
    else $error("disabled block kept a manual preset");
  a_bus_ret: assert property (ev_ret && !q.ctrl.restore |=> q.mode == MODE_AUTO)
    else $error("bus return did not select auto");
  a_irdis_keep: assert property (q.ctrl.ir_dis && !fb1_off && !ev_ret
    && !(test_go && q.walk) |=> $stable(q.mode))
    else $error("ir disable changed the preset");
  a_manual_nolearn: assert property (manual && !q.learn && i_cmd.valid
    && i_cmd.code == CMD_START |=> !q.learn)
    else $error("start accepted in manual mode");
  a_walk_exit: assert property ($fell(q.walk) |-> q.mode == MODE_AUTO)
    else $error("leaving walk test did not select auto");
  a_learn_start: assert property (start_go |-> s_learn_start)
    else $error("start did not launch learning");
  a_learn_cap: assert property (q.learn |-> q.learn_s <= LEARN_MAX_S)
    else $error("learning timer passed its limit");
  a_factor_ign: assert property (q.learn && wr_factor && !dly_go && !rst_go && !stop_go
    && !ev_dl |=> $stable(q.delay))
    else $error("factor value taken during learning");
  a_ack_flash: assert property (start_go |=> o_ack_led [*2])
    else $error("accepted command not acknowledged");
  a_auto_quiet: assert property (auto_go && !on_go && !off_go && !start_go && !stop_go
    |=> o_tx == '0)
    else $error("auto command sent a telegram");

endmodule // ir_remote_command_handler

// *** sim/remote_model.sv ***
// handheld remote model: sends decoded button reports to the handler
// assumes the handler samples i_cmd on the rising edge of i_clk
`timescale 1ns/1ps

module remote_model
  import ir_remote_pkg::*;
(
  input wire logic i_clk,
  output ir_remote_pkg::cmd_in_t o_cmd
);
  initial o_cmd = '0;

  // one report per press, a single-cycle pulse
  task automatic press(input cmd_t code, input logic [7:0] hold);
    @(posedge i_clk);
    o_cmd <= '{valid: 1'b1, code: code, hold: hold};
    @(posedge i_clk);
    o_cmd <= '0;
  endtask
endmodule // remote_model

// *** sim/ir_remote_command_handler_tb.sv ***
// bench for the infrared remote command handler
// assumes remote_model drives i_cmd; registers are reached by the plain port
`timescale 1ns/1ps

module ir_remote_command_handler_tb;
  import ir_remote_pkg::*;
  localparam int SEC = 4;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  cmd_in_t cmd;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [31:0] i_wdata = '0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic adj_v = 1'b0;
  adj_t adj_s = ADJ_NONE;
  logic pres = 1'b0;
  logic [31:0] rdata;
  logic [31:0] rv;
  mode_t mode;
  tx_t tx;
  logic fb1_hold, walk, indep, day, ack;
  logic [SENS_ALL_W-1:0] sens;
  logic [DLY_W-1:0] dly;
  logic [15:0] twi;
  cmd_t dc[5] = '{CMD_DLY_30S, CMD_DLY_2M, CMD_DLY_5M, CMD_DLY_30M, CMD_DLY_10S};
  logic [DLY_W-1:0] dv[5] = '{DLY_30S, DLY_2M, DLY_5M, DLY_30M, DLY_10S};
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;

  always #12.5 i_clk = ~i_clk;

  remote_model remote (.i_clk(i_clk), .o_cmd(cmd));

  ir_remote_command_handler #(.SEC_CYC(SEC), .FLASH_CYC(3)) dut (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_cmd(cmd), .i_adj_valid(adj_v),
    .i_adj_step(adj_s), .i_brightness(16'h0123), .i_presence(pres),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata),
    .o_mode(mode), .o_fb1_hold(fb1_hold), .o_walk_test(walk), .o_bright_indep(indep),
    .o_tx(tx), .o_sens(sens), .o_delay_s(dly), .o_twilight(twi), .o_twi_day(day),
    .o_ack_led(ack));

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 rv = rdata;
  endtask

  // results of a press land one edge after the report, tx pulses only then
  task automatic pr(input cmd_t c, input logic [7:0] h = 8'h00);
    remote.press(c, h);
    #1;
  endtask

  task automatic complete_run();
    if (mismatches == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // a hang counts as a mismatch; the full run needs well under 2000 cycles
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      complete_run();
    end
  end

  initial
  begin
    repeat (4) @(posedge i_clk);
    i_reset_n <= 1'b1;
    rd(A_CTRL);
    chk("ctrl", 32'h8, rv);
    chk("sens", 32'(RST_SENS), 32'(sens));
    rd(4'hf);
    chk("unmapped", 32'h0, rv);
    wr(A_CTRL, 32'h0a);
    pr(CMD_TWI_10);
    chk("twi10", 32'(LUX_10), 32'(twi));
    chk("ack", 32'h1, 32'(ack));
    pr(CMD_TWI_50);
    chk("twi50", 32'(LUX_50), 32'(twi));
    pr(CMD_TWI_150);
    chk("twi150", 32'(LUX_150), 32'(twi));
    pr(CMD_TWI_DAY);
    chk("day", 32'h1, 32'(day));
    pr(CMD_TEACH);
    chk("teach", 32'h123, 32'(twi));
    wr(A_CTRL, 32'h08);
    pr(CMD_TWI_50);
    chk("twi off", 32'h123, 32'(twi));
    for (int i = 0; i < 5; i++)
    begin
      pr(dc[i]);
      chk("delay", 32'(dv[i]), 32'(dly));
    end
    wr(A_CFG_SENS, 32'h108);
    wr(A_EVENT, 32'h1);
    chk("download", 32'h108, 32'(sens));
    pr(CMD_SENS_UP);
    pr(CMD_SENS_UP);
    chk("up", 32'h110, 32'(sens));
    pr(CMD_SENS_DN);
    chk("down", 32'h0c8, 32'(sens));
    pr(CMD_OFF);
    chk("off tx", 32'h02, 32'(tx));
    chk("off", 32'(MODE_OFF), 32'(mode));
    chk("indep", 32'h1, 32'(indep));
    pr(CMD_START);
    chk("start man", 32'h0, 32'(fb1_hold));
    pr(CMD_TEST);
    chk("walk", 32'h1, 32'(walk));
    chk("walk mode", 32'(MODE_OFF), 32'(mode));
    pr(CMD_DLY_30S);
    chk("walk dly", 32'(DLY_10S), 32'(dly));
    pr(CMD_SENS_EQ);
    chk("walk eq", 32'h108, 32'(sens));
    pr(CMD_TEST);
    chk("walk end", 32'(MODE_AUTO), 32'(mode));
    pr(CMD_ON);
    pr(CMD_AUTO);
    chk("auto tx", 32'h0, 32'(tx));
    chk("auto", 32'(MODE_AUTO), 32'(mode));
    pr(CMD_START);
    chk("begin", 32'h01, 32'(tx));
    chk("hold", 32'h1, 32'(fb1_hold));
    repeat (3 * SEC) @(posedge i_clk);
    wr(A_FACTOR, 32'h4d);
    chk("factor", 32'(DLY_10S), 32'(dly));
    rd(A_LEARN);
    pr(CMD_STOP);
    chk("end tx", 32'h02, 32'(tx));
    chk("learned", 32'h1, 32'(dly >= rv[DLY_W-1:0] && dly <= rv[DLY_W-1:0] + 1));
    chk("release", 32'h0, 32'(fb1_hold));
    pr(CMD_START);
    pr(CMD_DLY_2M);
    chk("abort tx", 32'h0, 32'(tx));
    chk("abort", 32'h0, 32'(fb1_hold));
    chk("abort dly", 32'(DLY_2M), 32'(dly));
    pr(CMD_ON);
    wr(A_CTRL, 32'h28);
    pr(CMD_AUTO);
    chk("ir dis", 32'(MODE_ON), 32'(mode));
    wr(A_CTRL, 32'h48);
    pr(CMD_ON);
    chk("fb1 dis", 32'(MODE_AUTO), 32'(mode));
    wr(A_CTRL, 32'h08);
    wr(A_CFG_DELAY, 32'h3c);
    wr(A_CFG_TWI, 32'h1f4);
    pr(CMD_OFF);
    pr(CMD_SENS_UP);
    pr(CMD_RESET, 8'd29);
    chk("reset early", 32'h110, 32'(sens));
    pr(CMD_RESET, 8'd30);
    chk("reset sens", 32'h108, 32'(sens));
    chk("reset dly", 32'h3c, 32'(dly));
    chk("reset twi", 32'h1f4, 32'(twi));
    chk("reset mode", 32'(MODE_OFF), 32'(mode));
    wr(A_EVENT, 32'h4);
    repeat (2) @(posedge i_clk);
    #1;
    chk("bus ret", 32'(MODE_AUTO), 32'(mode));
    chk("twi kept", 32'h1f4, 32'(twi));
    wr(A_EVENT, 32'h2);
    chk("bus teach", 32'h123, 32'(twi));
    wr(A_TWI_BUS, 32'h55);
    chk("twi bus", 32'h55, 32'(twi));
    @(posedge i_clk);
    adj_v <= 1'b1;
    adj_s <= ADJ_UP;
    pres <= 1'b1;
    @(posedge i_clk);
    adj_v <= 1'b0;
    #1;
    chk("adjuster", 32'h110, 32'(sens));
    pr(CMD_SENS_DN);
    chk("remote last", 32'h0c8, 32'(sens));
    wr(A_CTRL, 32'h0c);
    pr(CMD_OFF);
    wr(A_EVENT, 32'h4);
    chk("restore", 32'(MODE_OFF), 32'(mode));
    wr(A_CTRL, 32'h09);
    pr(CMD_OFF);
    chk("stepdown", 32'h08, 32'(tx));
    wr(A_CTRL, 32'h19);
    pr(CMD_OFF);
    chk("dim min", 32'h10, 32'(tx));
    pr(CMD_AUTO);
    pr(CMD_START);
    chk("startup", 32'h04, 32'(tx));
    pr(CMD_STOP);
    chk("stop light", 32'h08, 32'(tx));
    wr(A_CTRL, 32'h00);
    pr(CMD_TEST);
    chk("test off", 32'h0, 32'(walk));
    pr(CMD_ON);
    wr(A_CTRL, 32'h80);
    pr(CMD_ON);
    chk("fb1 inact", 32'(MODE_AUTO), 32'(mode));
    complete_run();
  end
endmodule // ir_remote_command_handler_tb
